// ### src/acp_config_port.sv
`timescale 1ns/1ns
`default_nettype none
module acp_config_port #(
    parameter logic [3:0] REVISION = 4'h0 // arbitrary value
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic device_reset_n,
    input wire logic cfg_serial_in,
    input wire logic cfg_shift_clock,
    input wire logic data_shift_clock,
    input wire logic chain_in,
    input wire logic integrate_toggle,
    output logic serial_out,
    output logic internal_clock_en,
    output logic [1:0] full_scale_range,
    output logic word_width_20,
    output logic speed_grade,
    output logic current_inputs_disconnect,
    output logic normal_operation,
    output logic [15:0] acquisition_setup
);

    acp_pkg::acp_mode_e mode;
    acp_pkg::acp_mode_e next_mode;
    acp_pkg::acp_setup_s setup_view;
    logic [15:0] shift_word;
    logic [4:0] bit_count;
    logic cfg_clk_prev;
    logic data_shift_clock_prev;
    logic toggle_prev;
    logic chain_hold;
    logic [1:0] prescale;
    logic cfg_fall;
    logic data_shift_clock_rise;
    logic data_shift_clock_fall;
    logic toggle_edge;
    logic word_complete;
    logic seq_bit;
    logic seq_done;
    logic rb_restart;
    logic rb_advance;
    logic rb_leaving;
    logic next_serial_out;
    logic next_clock_en;

    //------------------------------------------------------------
    // pin edge decoding
    //------------------------------------------------------------
    assign cfg_fall = cfg_clk_prev && !cfg_shift_clock;
    assign data_shift_clock_rise = !data_shift_clock_prev && data_shift_clock;
    assign data_shift_clock_fall = data_shift_clock_prev && !data_shift_clock;
    assign toggle_edge = toggle_prev != integrate_toggle;
    assign word_complete = (mode == acp_pkg::ACP_WRITE) && cfg_fall
                         && (bit_count == 5'(acp_pkg::SETUP_BITS - 1));
    assign rb_restart = !device_reset_n || word_complete;
    assign setup_view = acquisition_setup;

    // mode sequencing
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            acp_pkg::ACP_IDLE: next_mode = mode;
            acp_pkg::ACP_WRITE:
                if (word_complete)
                    next_mode = acp_pkg::ACP_READBACK;
            acp_pkg::ACP_READBACK:
                if (toggle_edge)
                    next_mode = acp_pkg::ACP_NORMAL;
            acp_pkg::ACP_NORMAL: next_mode = mode;
        endcase
        if (!device_reset_n)
            next_mode = acp_pkg::ACP_WRITE;
    end

    //------------------------------------------------------------
    // edge history
    //------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cfg_clk_prev <= 1'b0;
            data_shift_clock_prev <= 1'b0;
            toggle_prev <= 1'b0;
            mode <= acp_pkg::ACP_IDLE;
        end
        else
        begin
            cfg_clk_prev <= cfg_shift_clock;
            data_shift_clock_prev <= data_shift_clock;
            toggle_prev <= integrate_toggle;
            mode <= next_mode;
        end
    end

    // setup word shifting, msb first
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            shift_word <= acp_pkg::SETUP_RESET;
            bit_count <= 5'h00;
            acquisition_setup <= acp_pkg::SETUP_RESET;
        end
        else if (!device_reset_n)
        begin
            bit_count <= 5'h00;
            shift_word <= acp_pkg::SETUP_RESET;
        end
        else if (mode == acp_pkg::ACP_WRITE && cfg_fall)
        begin
            shift_word <= {shift_word[14:0], cfg_serial_in};
            bit_count <= bit_count + 5'h01;
            if (word_complete)
                acquisition_setup <= {shift_word[14:0], cfg_serial_in};
        end
    end

    //------------------------------------------------------------
    // readback generator
    //------------------------------------------------------------
    acp_readback_seq #(
        .REVISION(REVISION)
    ) u_seq (
        .clock(clock),
        .rst(rst),
        .restart(rb_restart),
        .advance(rb_advance),
        .word_width_20(setup_view.word_width_20),
        .setup_word(acquisition_setup),
        .seq_bit(seq_bit),
        .seq_done(seq_done)
    );

    //------------------------------------------------------------
    // serial output selection
    //------------------------------------------------------------
    // leaving readback clears the output in the same cycle that
    // normal_operation rises, so the pin is never busy in normal mode
    assign rb_advance = (mode == acp_pkg::ACP_READBACK) && data_shift_clock_rise;
    assign rb_leaving = (mode != acp_pkg::ACP_READBACK)
                      || (next_mode != acp_pkg::ACP_READBACK);
    assign next_serial_out = rb_leaving ? 1'b0
                           : (seq_done ? chain_hold : seq_bit);

    // chain capture on fall
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            chain_hold <= 1'b0;
        else if (data_shift_clock_fall)
            chain_hold <= chain_in;
    end

    // output register, moves on a rise or when leaving readback
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            serial_out <= 1'b0;
        else if (rb_leaving || data_shift_clock_rise)
            serial_out <= next_serial_out;
    end

    //------------------------------------------------------------
    // prescaler
    //------------------------------------------------------------
    // divide by four when bit 13 is set, else every cycle
    assign next_clock_en = !setup_view.clock_divide
                         || (prescale == acp_pkg::PRESCALE_LAST);

    // free-running phase counter and enable pulse
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            prescale <= 2'h0;
            internal_clock_en <= 1'b0;
        end
        else
        begin
            prescale <= prescale + 2'h1;
            internal_clock_en <= next_clock_en;
        end
    end

    //------------------------------------------------------------
    // decoded setup fields
    //------------------------------------------------------------
    // registered copies, one cycle behind the stored word; normal_operation is registered from next_mode
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            full_scale_range <= 2'h0;
            word_width_20 <= 1'b0;
            speed_grade <= 1'b0;
            current_inputs_disconnect <= 1'b0;
            normal_operation <= 1'b0;
        end
        else
        begin
            full_scale_range <= setup_view.full_scale_range;
            word_width_20 <= setup_view.word_width_20;
            speed_grade <= setup_view.speed_grade;
            current_inputs_disconnect <= setup_view.zero_input_test;
            normal_operation <= (next_mode == acp_pkg::ACP_NORMAL);
        end
    end

    //------------------------------------------------------------
    // elaboration checks
    //------------------------------------------------------------
    // one readback pass must be exactly half of the total count
    if (acp_pkg::LEAD_ZEROS_16 + acp_pkg::SETUP_BITS + acp_pkg::REV_BITS
        + acp_pkg::CHECK_LEN_16 != acp_pkg::TOTAL_16 / acp_pkg::SEQ_REPEATS)
    begin : g_len16_check
        $error("sixteen-bit readback figures do not add up");
    end
    if (acp_pkg::LEAD_ZEROS_20 + acp_pkg::SETUP_BITS + acp_pkg::REV_BITS
        + acp_pkg::CHECK_LEN_20 != acp_pkg::TOTAL_20 / acp_pkg::SEQ_REPEATS)
    begin : g_len20_check
        $error("twenty-bit readback figures do not add up");
    end
    // the non-zero tails must match the stored patterns
    if ($bits(acp_pkg::CHECK_PAT_16) != acp_pkg::CHECK_NZ_16
        || $bits(acp_pkg::CHECK_PAT_20) != acp_pkg::CHECK_NZ_20)
    begin : g_tail_check
        $error("check pattern widths do not match");
    end

endmodule : acp_config_port
`default_nettype wire

// ### src/acp_pkg.sv
//------------------------------------------------------------
//------------------------------------------------------------
package acp_pkg;

    // setup word layout
    typedef struct packed {
        logic [1:0] zero_hi;
        logic clock_divide;
        logic [1:0] zero_mid;
        logic [1:0] full_scale_range;
        logic word_width_20;
        logic speed_grade;
        logic [1:0] zero_lo;
        logic reserved;
        logic [2:0] zero_test;
        logic zero_input_test;
    } acp_setup_s;

    localparam int unsigned SETUP_BITS = 16;
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;

    // readback sequence figures
    localparam int unsigned LEAD_ZEROS_16 = 256;
    localparam int unsigned LEAD_ZEROS_20 = 320;
    localparam int unsigned REV_BITS = 4;
    localparam int unsigned CHECK_LEN_16 = 236;
    localparam int unsigned CHECK_LEN_20 = 300;
    localparam int unsigned CHECK_NZ_16 = 56;
    localparam int unsigned CHECK_NZ_20 = 72;
    localparam logic [71:0] CHECK_PAT_20 = 72'h30_f066_0124_80f6_9055;
    localparam logic [55:0] CHECK_PAT_16 = 56'h30_f066_0124_80f6;
    localparam int unsigned SEQ_REPEATS = 2;
    localparam int unsigned TOTAL_16 = 1024;
    localparam int unsigned TOTAL_20 = 1280;

    // host-side waits, ns, us and ms
    localparam int unsigned CLOCK_PERIOD_NS = 4;
    localparam int unsigned RESET_TO_SHIFT_US = 2;
    localparam int unsigned WRITE_TO_READ_US = 2;
    localparam int unsigned RESET_WIDTH_US = 1;
    localparam int unsigned POWER_UP_WAIT_MS = 250;

    // configuration port modes
    typedef enum logic [1:0] {
        ACP_IDLE = 2'b00,
        ACP_WRITE = 2'b01,
        ACP_READBACK = 2'b11,
        ACP_NORMAL = 2'b10
    } acp_mode_e;

endpackage : acp_pkg

// ### src/acp_readback_seq.sv
`timescale 1ns/1ns
`default_nettype none
module acp_readback_seq #(
    parameter logic [3:0] REVISION = 4'h0 // arbitrary value
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic restart,
    input wire logic advance,
    input wire logic word_width_20,
    input wire logic [15:0] setup_word,
    output logic seq_bit,
    output logic seq_done
);

    logic [10:0] position;
    logic [9:0] seq_pos;
    logic [10:0] total;

    //------------------------------------------------------------
    // bit selection
    //------------------------------------------------------------
    function automatic logic pick_bit(input logic [9:0] p, input logic fmt,
                                      input logic [15:0] word, input logic [3:0] rev);
        int lead;
        int clen;
        int nz;
        int q;
        lead = fmt ? acp_pkg::LEAD_ZEROS_20 : acp_pkg::LEAD_ZEROS_16;
        clen = fmt ? acp_pkg::CHECK_LEN_20 : acp_pkg::CHECK_LEN_16;
        nz = fmt ? acp_pkg::CHECK_NZ_20 : acp_pkg::CHECK_NZ_16;
        q = int'(p);
        if (q < lead)
            return 1'b0;
        q = q - lead;
        if (q < acp_pkg::SETUP_BITS)
            return word[acp_pkg::SETUP_BITS - 1 - q];
        q = q - acp_pkg::SETUP_BITS;
        if (q < acp_pkg::REV_BITS)
            return rev[acp_pkg::REV_BITS - 1 - q];
        q = q - acp_pkg::REV_BITS;
        if (q < clen - nz)
            return 1'b0;
        q = q - (clen - nz);
        if (fmt)
            return acp_pkg::CHECK_PAT_20[nz - 1 - q];
        return acp_pkg::CHECK_PAT_16[nz - 1 - q];
    endfunction : pick_bit

    // one sequence is half the total; the second pass repeats it
    assign total = word_width_20 ? 11'(acp_pkg::TOTAL_20) : 11'(acp_pkg::TOTAL_16);
    assign seq_pos = word_width_20 ? 10'(position % 11'd640) : 10'(position % 11'd512);
    assign seq_done = (position >= total);
    assign seq_bit = seq_done ? 1'b0
                   : pick_bit(seq_pos, word_width_20, setup_word, REVISION);

    //------------------------------------------------------------
    // bit counter
    //------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            position <= 11'h000;
        else if (restart)
            position <= 11'h000;
        else if (advance && !seq_done)
            position <= position + 11'h001;
    end

endmodule : acp_readback_seq
`default_nettype wire

// ### tb/acp_config_props.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// port checker
// ----
module acp_config_props #(
    parameter logic [3:0] REVISION = 4'h0
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic device_reset_n,
    input wire logic cfg_shift_clock,
    input wire logic data_shift_clock,
    input wire logic integrate_toggle,
    input wire logic serial_out,
    input wire logic internal_clock_en,
    input wire logic [1:0] full_scale_range,
    input wire logic word_width_20,
    input wire logic current_inputs_disconnect,
    input wire logic normal_operation,
    input wire logic [15:0] acquisition_setup
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // fields track the stored word one cycle late
    a_range_follow: assert property (full_scale_range == $past(acquisition_setup[10:9]))
        else $error("range field off");
    a_width_follow: assert property (word_width_20 == $past(acquisition_setup[8]))
        else $error("width field off");
    a_test_follow: assert property (current_inputs_disconnect == $past(acquisition_setup[0]))
        else $error("test field off");
    // prescaler off and on
    a_clkdiv_off: assert property (!acquisition_setup[13] && !$past(acquisition_setup[13], 3)
        && !$past(rst, 3) |-> internal_clock_en)
        else $error("undivided enable missing");
    a_div4_gap: assert property (internal_clock_en && acquisition_setup[13]
        && $past(acquisition_setup[13], 5) |=> !internal_clock_en [*3] ##1 internal_clock_en)
        else $error("divide by four spacing");
    // setup word only moves on a shift clock fall
    a_setup_on_fall: assert property ($changed(acquisition_setup)
        |-> !$past(cfg_shift_clock) && $past(cfg_shift_clock, 2))
        else $error("setup changed without fall");
    // output moves only after a data clock rise, a reset or normal entry
    a_out_on_rise: assert property ($changed(serial_out)
        |-> $past(data_shift_clock) || normal_operation || !$past(device_reset_n))
        else $error("serial out moved unclocked");
    a_quiet_normal: assert property (normal_operation |-> !serial_out)
        else $error("serial out busy in normal mode");
    a_normal_entry: assert property ($rose(normal_operation)
        |-> $past(integrate_toggle) != $past(integrate_toggle, 4))
        else $error("normal mode without toggle");

    c_normal: cover property ($rose(normal_operation));
    c_wide_rb: cover property (word_width_20 && serial_out);
    c_div4: cover property (acquisition_setup[13] && internal_clock_en);
endmodule : acp_config_props

bind acp_config_port acp_config_props #(.REVISION(REVISION)) props_u (
    .clock(clock), .rst(rst), .device_reset_n(device_reset_n),
    .cfg_shift_clock(cfg_shift_clock), .data_shift_clock(data_shift_clock),
    .integrate_toggle(integrate_toggle), .serial_out(serial_out),
    .internal_clock_en(internal_clock_en), .full_scale_range(full_scale_range),
    .word_width_20(word_width_20), .current_inputs_disconnect(current_inputs_disconnect),
    .normal_operation(normal_operation), .acquisition_setup(acquisition_setup));
`default_nettype wire

// ### tb/acp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// host controller model
// ----
module acp_host_model
(
    input wire logic clock,
    input wire logic serial_out,
    output logic device_reset_n,
    output logic cfg_serial_in,
    output logic cfg_shift_clock,
    output logic data_shift_clock,
    output logic chain_in,
    output logic integrate_toggle
);
    // all pins low until supplies settle
    initial {device_reset_n, cfg_serial_in, cfg_shift_clock} = 3'h0;
    initial {data_shift_clock, chain_in, integrate_toggle} = 3'h0;

    // wait n edges, then step just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    // reset strobe with integrate low
    task automatic reset_pulse();
        integrate_toggle = 1'b0;
        device_reset_n = 1'b0;
        cyc(250);
        device_reset_n = 1'b1;
        cyc(500);
    endtask : reset_pulse

    // shift n bits msb first, then invert the data line
    task automatic write_word(input logic [15:0] w, input int n);
        for (int i = 15; i > 15 - n; i--)
        begin
            cfg_serial_in = w[i];
            cfg_shift_clock = 1'b1;
            cyc(2);
            cfg_shift_clock = 1'b0;
            cyc(2);
        end
        cfg_serial_in = ~cfg_serial_in;
        cyc(500);
    endtask : write_word

    // one data clock with chain bit, sample after the fall
    task automatic data_shift_clock_pulse(input logic c, output logic b);
        chain_in = c;
        data_shift_clock = 1'b1;
        cyc(3);
        data_shift_clock = 1'b0;
        cyc(3);
        b = serial_out;
    endtask : data_shift_clock_pulse

    task automatic toggle();
        integrate_toggle = ~integrate_toggle;
        cyc(4);
    endtask : toggle
endmodule : acp_host_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// top bench
// ----
module testbench;
    localparam logic [3:0] REV = 4'h9; // arbitrary value
    logic clock, rst, device_reset_n, cfg_serial_in, cfg_shift_clock, data_shift_clock;
    logic chain_in, integrate_toggle, serial_out, internal_clock_en, word_width_20;
    logic speed_grade, current_inputs_disconnect, normal_operation;
    logic [1:0] full_scale_range;
    logic [15:0] acquisition_setup, w;
    int err_total, tests_run, seed, cycles, n;

    acp_host_model host_u (.clock(clock), .serial_out(serial_out),
        .device_reset_n(device_reset_n), .cfg_serial_in(cfg_serial_in),
        .cfg_shift_clock(cfg_shift_clock), .data_shift_clock(data_shift_clock),
        .chain_in(chain_in), .integrate_toggle(integrate_toggle));
    acp_config_port #(.REVISION(REV)) dut_u (.clock(clock), .rst(rst),
        .device_reset_n(device_reset_n), .cfg_serial_in(cfg_serial_in),
        .cfg_shift_clock(cfg_shift_clock), .data_shift_clock(data_shift_clock),
        .chain_in(chain_in), .integrate_toggle(integrate_toggle), .serial_out(serial_out),
        .internal_clock_en(internal_clock_en), .full_scale_range(full_scale_range),
        .word_width_20(word_width_20), .speed_grade(speed_grade),
        .current_inputs_disconnect(current_inputs_disconnect),
        .normal_operation(normal_operation), .acquisition_setup(acquisition_setup));

    // master clock never stops
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic cmp_bit(input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t: bit exp %b got %b", $time, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t: word exp %h got %h", $time, e, g);
        end
    endtask : cmp_word

    task automatic end_sim();
        $display("errors %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // model sequence: zeros, word, revision, check pattern, twice, then chain
    task automatic readback(input logic [15:0] s);
        bit q[$];
        logic [71:0] pat;
        logic got, c, cp;
        int nz;
        pat = s[8] ? 72'h30f066012480f69055 : {16'h0, 56'h30f066012480f6};
        nz = s[8] ? 72 : 56;
        repeat (2)
        begin
            repeat (s[8] ? 320 : 256) q.push_back(1'b0);
            for (int i = 15; i >= 0; i--) q.push_back(s[i]);
            for (int i = 3; i >= 0; i--) q.push_back(REV[i]);
            repeat (s[8] ? 228 : 180) q.push_back(1'b0);
            for (int i = nz - 1; i >= 0; i--) q.push_back(pat[i]);
        end
        cp = 1'b0;
        for (int k = 0; k < q.size() + 8; k++)
        begin
            c = 1'($random(seed));
            host_u.data_shift_clock_pulse(c, got);
            cmp_bit(k < q.size() ? q[k] : cp, got);
            cp = c;
        end
    endtask : readback

    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            $display("mismatch at %0t: timeout", $time);
            end_sim();
        end
    end

    initial
    begin
        seed = 3;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        #1 rst = 1'b0;
        host_u.reset_pulse();
        host_u.write_word(16'hffff, 7);
        for (int f = 0; f < 2; f++)
        begin
            host_u.reset_pulse();
            w = (16'($random(seed)) & 16'h0681) | (16'(f) << 8) | (16'(f) << 13);
            host_u.write_word(w, 16);
            cmp_word(w, acquisition_setup);
            cmp_word({5'h0, w[10:7], 6'h0, w[0]}, {5'h0, full_scale_range, word_width_20,
                speed_grade, 6'h0, current_inputs_disconnect});
            n = 0;
            repeat (8)
            begin
                host_u.cyc(1);
                n += int'(internal_clock_en);
            end
            cmp_word(w[13] ? 16'h0002 : 16'h0008, 16'(n));
            readback(w);
            cmp_bit(1'b0, normal_operation);
            host_u.toggle();
            cmp_bit(1'b1, normal_operation);
        end
        end_sim();
    end
endmodule : testbench
`default_nettype wire
